// ### test/codec_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module codec_host_model (
    // clock
    input  wire logic ref_clk,
    // serial control port
    output var  logic control_clock,
    output var  logic csN,
    output var  logic din,
    input  wire logic ctlDout,
    input  wire logic ctlDoutOe
);
    initial begin
        control_clock = 1'b1;
        csN  = 1'b1;
        din  = 1'b0;
    end

    // ***********************
    // byte shifting
    // ***********************
    // phases of 8 cycles leave room for the 3-cycle pin synchroniser
    // msb first, taken at each falling edge
    task automatic shiftByte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            @(posedge ref_clk);
            din  <= tx[i];
            control_clock <= 1'b1;
            repeat (8) @(posedge ref_clk);
            rx[i] = ctlDoutOe ? ctlDout : ~ctlDout;
            control_clock <= 1'b0;
            repeat (8) @(posedge ref_clk);
        end
    endtask

    // first byte carries power, address, read and length
    task automatic frame(input logic [7:0] b1, input logic [7:0] b2, input bit two,
                         output logic [7:0] rx);
        logic [7:0] unused;
        @(posedge ref_clk);
        csN <= 1'b0;
        repeat (4) @(posedge ref_clk);
        shiftByte(b1, unused);
        rx = 8'h00;
        if (two) begin
            shiftByte(b2, rx);
        end
        repeat (4) @(posedge ref_clk);
        csN <= 1'b1;
        // a released data line must not keep looking valid
        din <= ~din;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ### test/test_codec_program_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_codec_program_control;
    import codec_ctl_pkg::*;
    logic       ref_clk;
    logic       rst;
    logic       control_clock;
    logic       csN;
    logic       din;
    logic       tx_frame_sync;
    logic       rx_frame_sync;
    logic [5:0] latchIn;
    pin_s       pins;
    out_s       o;
    logic       pdNow;
    logic [7:0] rx;
    logic [7:0] ctlTab [4] = '{8'h25, 8'hd0, 8'hbe, 8'h72};
    int         errors;
    int         checked;

    assign pins = {control_clock, csN, din, tx_frame_sync, rx_frame_sync, latchIn};

    codec_program_control codec_program_control_i (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .ctlPins  (pins),
        .codecOut (o)
    );

    codec_host_model codec_host_model_i (
        .ref_clk   (ref_clk),
        .control_clock      (control_clock),
        .csN       (csN),
        .din       (din),
        .ctlDout   (o.ctlDout),
        .ctlDoutOe (o.ctlDoutOe)
    );

    // ***********************
    // helpers
    // ***********************
    task automatic chkRd(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t read got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkPort(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t port got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic pd, input logic [3:0] a, input logic [7:0] d);
        pdNow = pd;
        codec_host_model_i.frame({pd, a, 3'b010}, d, 1'b1, rx);
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        codec_host_model_i.frame({pdNow, a, 3'b110}, 8'h00, 1'b1, d);
    endtask

    task automatic pulse(input bit tx);
        @(posedge ref_clk);
        if (tx) tx_frame_sync <= 1'b1; else rx_frame_sync <= 1'b1;
        repeat (4) @(posedge ref_clk);
        tx_frame_sync <= 1'b0;
        rx_frame_sync <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask

    function automatic logic [15:0] ctlExp(input logic [7:0] c);
        return {7'h0, c[7:6], c[5], c[5] & ~c[4], c[3], ~c[3], c[2], ~c[2] & c[1], ~c[2] & c[1]};
    endfunction

    function automatic logic [7:0] latchExp(input logic [7:0] dir, input logic [7:0] val,
                                            input logic [5:0] pin);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 6; i++) begin
            r[7-i] = dir[7-i] ? val[7-i] : pin[i];
        end
        return r;
    endfunction

    task automatic results();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ***********************
    // clock, watchdog
    // ***********************
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    initial begin
        repeat (60000) @(posedge ref_clk);
        errors++;
        results();
    end

    // ***********************
    // tests
    // ***********************
    initial begin
        rst = 1'b1; tx_frame_sync = 1'b0; rx_frame_sync = 1'b0; latchIn = 6'h17; pdNow = 1'b1;
        errors = 0; checked = 0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chkPort(16'({o.powerDown, o.frameOffsetMode, o.rxAmpOn, o.latchOe, o.txEn0}),
                16'h0380);
        rd(ADDR_CTRL, rx); chkRd(rx, CTRL_RST);
        rd(ADDR_LVAL, rx); chkRd(rx, latchExp(8'h00, 8'h00, latchIn));
        rd(ADDR_TXSLOT, rx); chkRd(rx, SLOT_RST);
        wr(1'b1, 4'h6, 8'h00); // hybrid balance off before analog loop
        // host sets the divider while still powered down
        foreach (ctlTab[k]) begin
            wr(1'b1, ADDR_CTRL, ctlTab[k]);
            chkPort(16'({o.divCode, o.aLaw, o.evenInvert, o.frameOffsetMode,
                         o.tsaMode, o.echoLoop, o.lineLoop, o.txVoiceFromRx}),
                    ctlExp(ctlTab[k]));
            chkPort(16'({o.powerDown, o.rxAmpOn, o.rxVoiceOn}),
                    {13'h0, 1'b1, ~ctlTab[k][0], 1'b0});
            rd(ADDR_CTRL, rx); chkRd(rx, ctlTab[k]);
        end
        wr(1'b1, 4'h5, 8'hff);
        rd(4'h5, rx); chkRd(rx, 8'h00);
        rd(ADDR_CTRL, rx); chkRd(rx, 8'h72);
        wr(1'b1, ADDR_TXSLOT, 8'h85);
        wr(1'b1, ADDR_RXSLOT, 8'hc3);
        pulse(1'b0);
        chkPort(16'({o.rxEn1, o.rxEn0}), 16'h0000);
        pulse(1'b0);
        chkPort(16'({o.rxEn1, o.rxEn0, o.rxSlotNum}), 16'h0003);
        pulse(1'b1);
        pulse(1'b1);
        // lone power byte keeps its length bit clear
        pdNow = 1'b0;
        codec_host_model_i.frame(8'h00, 8'h00, 1'b0, rx);
        chkPort(16'({o.powerDown, o.rxVoiceOn, o.rxAmpOn, o.txEn0}), 16'h0006);
        chkPort(16'({o.rxEn1, o.rxEn0}), 16'h0002);
        pulse(1'b1);
        chkPort(16'({o.txEn1, o.txEn0}), 16'h0000);
        pulse(1'b1);
        chkPort(16'({o.txEn1, o.txEn0, o.txSlotNum}), 16'h0045);
        rd(ADDR_TXSLOT, rx); chkRd(rx, 8'h85);
        // values first, then directions; unused latches as outputs
        wr(1'b0, ADDR_LVAL, 8'ha4);
        wr(1'b0, ADDR_LDIR, 8'h3f);
        chkPort(16'({o.latchOe, o.latchOut}), 16'h0f25);
        rd(ADDR_LVAL, rx); chkRd(rx, latchExp(8'h3c, 8'ha4, latchIn));
        rd(ADDR_LDIR, rx); chkRd({rx[7:2], 2'b00}, 8'h3c);
        wr(1'b1, ADDR_CTRL, 8'h73);
        chkPort(16'({o.powerDown, o.rxAmpOn}), 16'h0002);
        results();
    end
endmodule
`default_nettype wire

// ### verilog/codec_ctl_pkg.sv
package codec_ctl_pkg;
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_LDIR   = 4'h2;
    localparam logic [3:0] ADDR_LVAL   = 4'h1;
    localparam logic [3:0] ADDR_TXSLOT = 4'ha;
    localparam logic [3:0] ADDR_RXSLOT = 4'h9;
    localparam logic [7:0] CTRL_RST    = 8'h08;
    localparam logic [7:0] LDIR_RST    = 8'h00;
    localparam logic [7:0] LVAL_RST    = 8'h00;
    localparam logic [7:0] SLOT_RST    = 8'h00;
    localparam int B1_POWER   = 7;
    localparam int B1_READ    = 2;
    localparam int B1_LEN     = 1;
    localparam int CTRL_LAW   = 5;
    localparam int CTRL_INV   = 4;
    localparam int CTRL_OFS   = 3;
    localparam int CTRL_ECHO  = 2;
    localparam int CTRL_LINE  = 1;
    localparam int CTRL_AMP   = 0;
    localparam int SLOT_EN    = 7;
    localparam int SLOT_PORT  = 6;
    localparam int LATCH_TOP  = 7;
    localparam int NUM_LATCH  = 6;
    localparam logic [1:0] FRAMES_TO_APPLY = 2'h2;
    localparam logic [1:0] FS_AFTER_PUP    = 2'h2;

    typedef enum logic [0:0] {PH_CMD, PH_DATA} phase_e;

    typedef struct packed {
        logic       control_clock;
        logic       csN;
        logic       din;
        logic       tx_frame_sync;
        logic       rx_frame_sync;
        logic [5:0] latchIn;
    } pin_s;

    typedef struct packed {
        logic       powerDown;
        logic       txEn0;
        logic       txEn1;
        logic       rxEn0;
        logic       rxEn1;
        logic [5:0] txSlotNum;
        logic [5:0] rxSlotNum;
        logic       tsaMode;
        logic [1:0] divCode;
        logic       aLaw;
        logic       evenInvert;
        logic       frameOffsetMode;
        logic       echoLoop;
        logic       lineLoop;
        logic       txVoiceFromRx;
        logic       rxVoiceOn;
        logic       rxAmpOn;
        logic [5:0] latchOut;
        logic [5:0] latchOe;
        logic       ctlDout;
        logic       ctlDoutOe;
    } out_s;
endpackage

// ### verilog/codec_program_control.sv
`timescale 1ns/1ps
`default_nettype none
module codec_program_control
    import codec_ctl_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst,
    // pins from outside, asynchronous
    input  wire pin_s ctlPins,
    // all outputs, registered
    output var  out_s codecOut
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        pin_s       syncA;
        pin_s       syncB;
        pin_s       syncC;
        logic [6:0] shift;
        logic [2:0] bitCnt;
        phase_e     phase;
        logic [7:0] cmd;
        logic [7:0] outSh;
        logic       dout;
        logic       pd;
        logic [7:0] ctrl;
        logic [7:0] ldir;
        logic [7:0] lval;
        logic [7:0] txSlot;
        logic [7:0] rxSlot;
        logic [7:0] txPend;
        logic [7:0] rxPend;
        logic       txWrit;
        logic       rxWrit;
        logic [1:0] txCnt;
        logic [1:0] rxCnt;
        logic [1:0] fsxSeen;
        out_s       o;
    } state_s;

    state_s     st_r;
    state_s     st_nxt;
    logic [7:0] rxByte;
    logic       cclkFall;
    logic       cclkRise;
    logic       csRise;
    logic       fsxRise;
    logic       fsrRise;
    logic       cmdDone;
    logic       wrStrobe;
    logic       txOk;
    logic       rxOk;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [5:0] latch_bits(input logic [7:0] b);
        logic [5:0] r;
        r = '0;
        for (int i = 0; i < NUM_LATCH; i++) begin
            r[i] = b[LATCH_TOP-i];
        end
        return r;
    endfunction

    function automatic logic [7:0] latch_read(input logic [7:0] dir,
                                              input logic [7:0] val,
                                              input logic [5:0] pin);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < NUM_LATCH; i++) begin
            r[LATCH_TOP-i] = dir[LATCH_TOP-i] ? val[LATCH_TOP-i] : pin[i];
        end
        return r;
    endfunction

    // edges are taken from the second and third stages only
    assign rxByte   = {st_r.shift, st_r.syncB.din};
    assign cclkFall = !st_r.syncB.control_clock && st_r.syncC.control_clock;
    assign cclkRise = st_r.syncB.control_clock && !st_r.syncC.control_clock;
    assign csRise   = st_r.syncB.csN && !st_r.syncC.csN;
    assign fsxRise  = st_r.syncB.tx_frame_sync && !st_r.syncC.tx_frame_sync;
    assign fsrRise  = st_r.syncB.rx_frame_sync && !st_r.syncC.rx_frame_sync;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_nxt   = st_r;
        cmdDone  = 1'b0;
        wrStrobe = 1'b0;
        st_nxt.syncA = ctlPins;
        st_nxt.syncB = st_r.syncA;
        st_nxt.syncC = st_r.syncB;
        if (st_r.syncB.csN) begin
            st_nxt.bitCnt = '0;
            st_nxt.phase  = PH_CMD;
        end else if (cclkFall) begin
            st_nxt.shift  = rxByte[6:0];
            st_nxt.bitCnt = st_r.bitCnt + 3'h1;
            if (st_r.bitCnt == 3'h7) begin
                if (st_r.phase == PH_CMD) begin
                    cmdDone = 1'b1;
                    st_nxt.pd = rxByte[B1_POWER];
                    if (rxByte[B1_LEN]) begin
                        st_nxt.phase = PH_DATA;
                        st_nxt.cmd   = rxByte;
                        case (rxByte[6:3])
                            ADDR_CTRL:   st_nxt.outSh = st_r.ctrl;
                            ADDR_LDIR:   st_nxt.outSh = st_r.ldir;
                            ADDR_LVAL:   st_nxt.outSh = latch_read(st_r.ldir, st_r.lval,
                                                                   st_r.syncB.latchIn);
                            ADDR_TXSLOT: st_nxt.outSh = st_r.txSlot;
                            ADDR_RXSLOT: st_nxt.outSh = st_r.rxSlot;
                            default:     st_nxt.outSh = 8'h00;
                        endcase
                    end
                end else begin
                    st_nxt.phase = PH_CMD;
                    wrStrobe = !st_r.cmd[B1_READ];
                end
            end
        end else if (cclkRise && st_r.phase == PH_DATA && st_r.cmd[B1_READ]) begin
            st_nxt.dout  = st_r.outSh[7];
            st_nxt.outSh = {st_r.outSh[6:0], 1'b0};
        end

        // gain and balance addresses are accepted and dropped
        if (wrStrobe) begin
            case (st_r.cmd[6:3])
                ADDR_CTRL: st_nxt.ctrl = rxByte;
                ADDR_LDIR: st_nxt.ldir = rxByte;
                ADDR_LVAL: st_nxt.lval = rxByte;
                ADDR_TXSLOT: begin
                    st_nxt.txPend = rxByte;
                    st_nxt.txWrit = 1'b1;
                end
                ADDR_RXSLOT: begin
                    st_nxt.rxPend = rxByte;
                    st_nxt.rxWrit = 1'b1;
                end
                default: ;
            endcase
        end

        if (csRise && st_r.txWrit) begin
            st_nxt.txCnt  = FRAMES_TO_APPLY;
            st_nxt.txWrit = 1'b0;
        end else if (fsxRise && st_r.txCnt != 2'h0) begin
            st_nxt.txCnt = st_r.txCnt - 2'h1;
            if (st_r.txCnt == 2'h1) begin
                st_nxt.txSlot = st_r.txPend;
            end
        end
        if (csRise && st_r.rxWrit) begin
            st_nxt.rxCnt  = FRAMES_TO_APPLY;
            st_nxt.rxWrit = 1'b0;
        end else if (fsrRise && st_r.rxCnt != 2'h0) begin
            st_nxt.rxCnt = st_r.rxCnt - 2'h1;
            if (st_r.rxCnt == 2'h1) begin
                st_nxt.rxSlot = st_r.rxPend;
            end
        end

        if (st_r.pd) begin
            st_nxt.fsxSeen = '0;
        end else if (fsxRise && st_r.fsxSeen != FS_AFTER_PUP) begin
            st_nxt.fsxSeen = st_r.fsxSeen + 2'h1;
        end

        // ********************************************************
        // outputs, one cycle behind the state they show
        // ********************************************************
        // outputs held off
        txOk = !st_r.pd && st_r.fsxSeen == FS_AFTER_PUP && st_r.txSlot[SLOT_EN];
        rxOk = !st_r.pd && st_r.rxSlot[SLOT_EN];
        st_nxt.o.powerDown = st_r.pd;
        st_nxt.o.txEn0     = txOk && !st_r.txSlot[SLOT_PORT];
        st_nxt.o.txEn1     = txOk && st_r.txSlot[SLOT_PORT];
        st_nxt.o.rxEn0     = rxOk && !st_r.rxSlot[SLOT_PORT];
        st_nxt.o.rxEn1     = rxOk && st_r.rxSlot[SLOT_PORT];
        st_nxt.o.txSlotNum = st_r.txSlot[5:0];
        st_nxt.o.rxSlotNum = st_r.rxSlot[5:0];
        st_nxt.o.tsaMode   = !st_r.ctrl[CTRL_OFS];
        st_nxt.o.divCode   = st_r.ctrl[7:6];
        st_nxt.o.aLaw       = st_r.ctrl[CTRL_LAW];
        st_nxt.o.evenInvert = st_r.ctrl[CTRL_LAW] && !st_r.ctrl[CTRL_INV];
        st_nxt.o.frameOffsetMode = st_r.ctrl[CTRL_OFS];
        st_nxt.o.echoLoop = st_r.ctrl[CTRL_ECHO];
        st_nxt.o.lineLoop = !st_r.ctrl[CTRL_ECHO] && st_r.ctrl[CTRL_LINE];
        st_nxt.o.txVoiceFromRx = !st_r.ctrl[CTRL_ECHO] && st_r.ctrl[CTRL_LINE];
        st_nxt.o.rxVoiceOn = !st_r.pd;
        st_nxt.o.rxAmpOn   = !st_r.pd || !st_r.ctrl[CTRL_AMP];
        st_nxt.o.latchOut  = latch_bits(st_r.lval);
        st_nxt.o.latchOe   = latch_bits(st_r.ldir);
        st_nxt.o.ctlDout   = st_r.dout;
        st_nxt.o.ctlDoutOe = !st_r.syncB.csN && st_r.phase == PH_DATA
                             && st_r.cmd[B1_READ];
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_r             <= '0;
            st_r.pd          <= 1'b1;
            st_r.o.powerDown <= 1'b1;
            st_r.o.rxAmpOn   <= 1'b1;
            st_r.o.frameOffsetMode <= 1'b1;
            // idle pin levels, so no false select or clock edge follows reset
            st_r.syncA.csN   <= 1'b1;
            st_r.syncB.csN   <= 1'b1;
            st_r.syncC.csN   <= 1'b1;
            st_r.syncA.control_clock  <= 1'b1;
            st_r.syncB.control_clock  <= 1'b1;
            st_r.syncC.control_clock  <= 1'b1;
            st_r.ctrl        <= CTRL_RST;
            st_r.ldir        <= LDIR_RST;
            st_r.lval        <= LVAL_RST;
            st_r.txSlot      <= SLOT_RST;
            st_r.rxSlot      <= SLOT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign codecOut = st_r.o;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_power_bit: assert property (cmdDone |=> st_r.pd == $past(rxByte[B1_POWER]))
        else $error("power bit not taken from command byte");
    a_pup_txoff: assert property (!st_r.pd && st_r.fsxSeen != FS_AFTER_PUP
                                  |=> !codecOut.txEn0 && !codecOut.txEn1)
        else $error("transmit output enabled before second sync");
    a_law_select: assert property (!st_r.ctrl[CTRL_LAW]
                                   |=> !codecOut.aLaw && !codecOut.evenInvert)
        else $error("A-law shown while mu-law selected");
    a_echo_wins: assert property (st_r.ctrl[CTRL_ECHO]
                                  |=> codecOut.echoLoop && !codecOut.lineLoop)
        else $error("echo loop did not take priority");
    a_amp_hold: assert property (st_r.pd && st_r.ctrl[CTRL_AMP] |=> !codecOut.rxAmpOn)
        else $error("amplifier on while held off in power down");
    a_latch_dir: assert property (wrStrobe && st_r.cmd[6:3] == ADDR_LDIR
                                  |=> ##1 codecOut.latchOe == latch_bits($past(rxByte, 2)))
        else $error("latch direction not applied");
    a_ctrl_load: assert property (wrStrobe && st_r.cmd[6:3] == ADDR_CTRL
                                  |=> st_r.ctrl == $past(rxByte))
        else $error("control byte not loaded");
    a_slot_apply: assert property (fsxRise && st_r.txCnt == 2'h1 && !csRise
                                   |=> st_r.txSlot == $past(st_r.txPend))
        else $error("slot assignment not applied on second frame");
    a_slot_hold: assert property (st_r.txCnt == 2'h2 && !fsxRise && !wrStrobe
                                  |=> $stable(st_r.txSlot))
        else $error("slot assignment applied too early");
    a_dout_off: assert property (st_r.syncB.csN |=> !codecOut.ctlDoutOe)
        else $error("data out driven while select high");
    a_rx_slot_apply: assert property (fsrRise && st_r.rxCnt == 2'h1 && !csRise
                                      |=> st_r.rxSlot == $past(st_r.rxPend))
        else $error("receive slot assignment not applied on second frame");
    a_line_loop: assert property (!st_r.ctrl[CTRL_ECHO] && st_r.ctrl[CTRL_LINE]
                                  |=> codecOut.lineLoop && codecOut.txVoiceFromRx)
        else $error("analog loop not shown");
    a_latch_out: assert property (wrStrobe && st_r.cmd[6:3] == ADDR_LVAL
                                  |=> ##1 codecOut.latchOut == latch_bits($past(rxByte, 2)))
        else $error("latch values not applied");

    c_lone_power: cover property (cmdDone && !rxByte[B1_LEN]);
    c_read_back: cover property (codecOut.ctlDoutOe ##1 !codecOut.ctlDoutOe);
    c_slot_apply: cover property (fsxRise && st_r.txCnt == 2'h1);
    c_tx_enable: cover property (!codecOut.txEn0 ##1 codecOut.txEn0);
    c_line_loop: cover property (codecOut.lineLoop);

endmodule
`default_nettype wire
